// *** cls_consts.svh ***
// Constants for the clock loop settling model: codes, thresholds and timing.
// Assumes inclusion by the design module and the testbench only.
`ifndef CLS_CONSTS_SVH
`define CLS_CONSTS_SVH
`define CLS_DIV_MAX          4'h9
`define CLS_STAGE_RST        8'h80
`define CLS_DIV_RST          4'h0
`define CLS_COARSE_PCT       8'h0F
`define CLS_FINE_PCT         8'h05
`define CLS_COARSE_STEPS     4'h8
`define CLS_MEDIUM_MAX       4'h8
`define CLS_FINE_MAX         5'h18
`define CLS_BASE_PER_CORR    3'h4
`define CLS_COARSE_UNIT      16'h002C
`define CLS_COARSE_STAGE     8'h20
`define CLS_MEDIUM_STEP      8'h04
`define CLS_FINE_STEP        8'h01
`endif

// *** cls_pkg.sv ***
// Types for the clock loop settling model.
// Assumes cls_consts.svh supplies every numeric constant.
package cls_pkg;
  typedef enum logic [1:0] {
    CLS_OFF    = 2'b00,
    CLS_COARSE = 2'b01,
    CLS_MEDIUM = 2'b10,
    CLS_FINE   = 2'b11
  } cls_regime_t;
endpackage : cls_pkg

// *** cls_loop.sv ***
// Digital loop filter settling model for the internal oscillator.
// Assumes err_pct and err_slow come from a frequency comparator on clk;
// the base clock and oscillator clock arrive as pins and are synchronised.
`include "cls_consts.svh"
module cls_loop
  import cls_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       internal_gen_on,
  input  wire logic       low_freq_base_clock,
  input  wire logic       internal_osc_clock,
  input  wire logic [6:0] mult_n,
  input  wire logic [7:0] err_pct,
  input  wire logic       err_slow,
  input  wire logic       wr_div,
  input  wire logic [3:0] wr_div_data,
  input  wire logic       wr_stage,
  input  wire logic [7:0] wr_stage_data,
  output logic      [3:0] osc_divider_code,
  output logic      [7:0] osc_stage_code,
  output logic            internal_clock_stable,
  output logic      [1:0] regime,
  output logic            corr_pulse
);
  function automatic logic [3:0] sat_div(input logic [3:0] d);
    sat_div = (d > `CLS_DIV_MAX) ? `CLS_DIV_MAX : d;
  endfunction : sat_div

  // Stage move with the carry or borrow kept in bit 8 for the divider
  function automatic logic [8:0] stage_step(input logic [7:0] s,
                                            input logic       up,
                                            input logic [7:0] amt);
    stage_step = up ? {1'b0, s} + {1'b0, amt} : {1'b0, s} - {1'b0, amt};
  endfunction : stage_step

  // Two-stage synchronisers; first stage read only by the second
  logic [1:0] base_sync_reg;
  logic [1:0] osc_sync_reg;
  logic       base_prev_reg;
  logic       osc_prev_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      base_sync_reg <= 2'b00;
      osc_sync_reg  <= 2'b00;
      base_prev_reg <= 1'b0;
      osc_prev_reg  <= 1'b0;
    end else begin
      base_sync_reg <= {base_sync_reg[0], low_freq_base_clock};
      osc_sync_reg  <= {osc_sync_reg[0], internal_osc_clock};
      base_prev_reg <= base_sync_reg[1];
      osc_prev_reg  <= osc_sync_reg[1];
    end
  end
  logic base_rise;
  logic osc_rise;
  assign base_rise = base_sync_reg[1] & ~base_prev_reg;
  assign osc_rise  = osc_sync_reg[1] & ~osc_prev_reg;

  cls_regime_t regime_reg, regime_next;
  logic [3:0]  div_reg, div_next;
  logic [7:0]  stage_reg, stage_next;
  logic        stable_reg, stable_next;
  logic        corr_reg, corr_next;
  logic [2:0]  base_cnt_reg, base_cnt_next;
  logic [22:0] osc_cnt_reg, osc_cnt_next;
  logic [22:0] coarse_len_reg, coarse_len_next;
  logic [3:0]  coarse_steps_reg, coarse_steps_next;
  logic [3:0]  med_cnt_reg, med_cnt_next;
  logic [4:0]  fine_cnt_reg, fine_cnt_next;
  logic        due;
  logic [8:0]  stage_sum;

  always_comb begin
    regime_next       = regime_reg;
    div_next          = div_reg;
    stage_next        = stage_reg;
    stable_next       = stable_reg;
    corr_next         = 1'b0;
    base_cnt_next     = base_cnt_reg;
    osc_cnt_next      = osc_cnt_reg;
    coarse_len_next   = coarse_len_reg;
    coarse_steps_next = coarse_steps_reg;
    med_cnt_next      = med_cnt_reg;
    fine_cnt_next     = fine_cnt_reg;
    due               = 1'b0;
    stage_sum         = 9'h000;
    if (!internal_gen_on) begin
      // Generator off: hold the loop and accept preloads
      regime_next   = CLS_OFF;
      stable_next   = 1'b0;
      base_cnt_next = 3'h0;
      osc_cnt_next  = 23'h00_0000;
      if (wr_div)
        div_next = sat_div(wr_div_data);
      if (wr_stage)
        stage_next = wr_stage_data;
    end else begin
      unique case (regime_reg)
        CLS_OFF: begin
          // Start from the preloaded point, not a fixed start
          regime_next       = CLS_COARSE;
          coarse_len_next   = 23'(`CLS_COARSE_UNIT) * 23'(mult_n) / 23'(`CLS_COARSE_STEPS);
          coarse_steps_next = 4'h0;
          med_cnt_next      = 4'h0;
          fine_cnt_next     = 5'h00;
        end
        CLS_COARSE: begin
          if (osc_rise)
            osc_cnt_next = osc_cnt_reg + 23'h00_0001;
          due = osc_cnt_reg >= coarse_len_reg;
        end
        CLS_MEDIUM, CLS_FINE: begin
          if (base_rise)
            base_cnt_next = base_cnt_reg + 3'h1;
          due = base_cnt_reg == `CLS_BASE_PER_CORR - 3'h1 && base_rise;
        end
      endcase
      if (regime_reg != CLS_OFF && err_pct <= `CLS_COARSE_PCT && regime_reg == CLS_COARSE)
        regime_next = CLS_MEDIUM;
      if (due) begin
        corr_next     = 1'b1;
        osc_cnt_next  = 23'h00_0000;
        base_cnt_next = 3'h0;
        unique case (regime_reg)
          CLS_COARSE: begin
            // Stage bit 5 steps; eight of them carry into the divider
            stage_sum = stage_step(stage_reg, err_slow, `CLS_COARSE_STAGE);
            coarse_steps_next = coarse_steps_reg + 4'h1;
            if (coarse_steps_reg == `CLS_COARSE_STEPS - 4'h1) begin
              coarse_steps_next = 4'h0;
              // Stop doubling at the top bit so a long pull cannot wrap to zero
              if (!coarse_len_reg[22])
                coarse_len_next = {coarse_len_reg[21:0], 1'b0};
            end
          end
          CLS_MEDIUM: begin
            stage_sum    = stage_step(stage_reg, err_slow, `CLS_MEDIUM_STEP);
            med_cnt_next = med_cnt_reg + 4'h1;
            if (err_pct < `CLS_FINE_PCT || med_cnt_reg == `CLS_MEDIUM_MAX - 4'h1) begin
              regime_next = CLS_FINE;
              stable_next = 1'b1;
            end
          end
          default: begin
            if (fine_cnt_reg != `CLS_FINE_MAX && err_pct != 8'h00) begin
              stage_sum     = stage_step(stage_reg, err_slow, `CLS_FINE_STEP);
              fine_cnt_next = fine_cnt_reg + 5'h01;
            end else begin
              // Settled or out of steps: nothing applied, so no pulse either
              stage_sum = {1'b0, stage_reg};
              corr_next = 1'b0;
            end
          end
        endcase
        stage_next = stage_sum[7:0];
        // Divider moves only on stage carry or borrow
        if (stage_sum[8] && err_slow && div_reg != `CLS_DIV_MAX)
          div_next = div_reg + 4'h1;
        else if (stage_sum[8] && err_slow)
          stage_next = 8'hFF;
        else if (stage_sum[8] && div_reg != 4'h0)
          div_next = div_reg - 4'h1;
        else if (stage_sum[8])
          stage_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      regime_reg       <= CLS_OFF;
      div_reg          <= `CLS_DIV_RST;
      stage_reg        <= `CLS_STAGE_RST;
      stable_reg       <= 1'b0;
      corr_reg         <= 1'b0;
      base_cnt_reg     <= 3'h0;
      osc_cnt_reg      <= 23'h00_0000;
      coarse_len_reg   <= 23'h00_0000;
      coarse_steps_reg <= 4'h0;
      med_cnt_reg      <= 4'h0;
      fine_cnt_reg     <= 5'h00;
    end else begin
      regime_reg       <= regime_next;
      div_reg          <= div_next;
      stage_reg        <= stage_next;
      stable_reg       <= stable_next;
      corr_reg         <= corr_next;
      base_cnt_reg     <= base_cnt_next;
      osc_cnt_reg      <= osc_cnt_next;
      coarse_len_reg   <= coarse_len_next;
      coarse_steps_reg <= coarse_steps_next;
      med_cnt_reg      <= med_cnt_next;
      fine_cnt_reg     <= fine_cnt_next;
    end
  end

  assign osc_divider_code      = div_reg;
  assign osc_stage_code        = stage_reg;
  assign internal_clock_stable = stable_reg;
  assign regime                = regime_reg;
  assign corr_pulse            = corr_reg;

  property p_div_sat;
    @(posedge clk) disable iff (!nrst) div_reg <= `CLS_DIV_MAX;
  endproperty
  a_div_sat: assert property (p_div_sat) else $error("divider above max");
  property p_preload;
    @(posedge clk) disable iff (!nrst)
      !internal_gen_on && wr_stage |=> stage_reg == $past(wr_stage_data);
  endproperty
  a_preload: assert property (p_preload) else $error("stage preload lost");
  property p_hold_on;
    @(posedge clk) disable iff (!nrst)
      internal_gen_on && !corr_next |=> $stable(stage_reg);
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("stage moved without correction");
  property p_stable_off;
    @(posedge clk) disable iff (!nrst) !internal_gen_on |=> !stable_reg;
  endproperty
  a_stable_off: assert property (p_stable_off) else $error("stable while off");
  property p_stable_fine;
    @(posedge clk) disable iff (!nrst) stable_reg |-> regime_reg == CLS_FINE;
  endproperty
  a_stable_fine: assert property (p_stable_fine) else $error("stable outside fine");
  property p_base4;
    @(posedge clk) disable iff (!nrst)
      corr_reg && regime_reg == CLS_FINE |-> base_cnt_reg == 3'h0;
  endproperty
  a_base4: assert property (p_base4) else $error("base count not cleared");
  property p_fine_max;
    @(posedge clk) disable iff (!nrst) fine_cnt_reg <= `CLS_FINE_MAX;
  endproperty
  a_fine_max: assert property (p_fine_max) else $error("too many fine steps");
  property p_med_max;
    @(posedge clk) disable iff (!nrst) med_cnt_reg <= `CLS_MEDIUM_MAX;
  endproperty
  a_med_max: assert property (p_med_max) else $error("too many medium steps");
  property p_coarse_step;
    @(posedge clk) disable iff (!nrst)
      regime_reg == CLS_COARSE && due && err_slow && stage_reg < 8'hE0
      |=> stage_reg == $past(stage_reg) + 8'h20;
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("coarse step size wrong");
endmodule : cls_loop

// *** cls_loop_tb.sv ***
// Self-checking bench for the clock loop settling model.
// Assumes cls_loop alone; the bench makes the base and oscillator pins.
`include "cls_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cls_pkg::*;
  logic       clk, nrst, internal_gen_on, err_slow, wr_div, wr_stage, corr_pulse;
  logic       internal_clock_stable;
  logic [6:0] mult_n;
  logic [7:0] err_pct, wr_stage_data, osc_stage_code, s0;
  logic [3:0] wr_div_data, osc_divider_code, tick, d0;
  logic [1:0] regime;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cyc, n;
  cls_loop cls_loop_i (.clk(clk), .nrst(nrst), .internal_gen_on(internal_gen_on),
    .low_freq_base_clock(tick[3]), .internal_osc_clock(tick[1]), .mult_n(mult_n),
    .err_pct(err_pct), .err_slow(err_slow), .wr_div(wr_div), .wr_div_data(wr_div_data),
    .wr_stage(wr_stage), .wr_stage_data(wr_stage_data), .osc_divider_code(osc_divider_code),
    .osc_stage_code(osc_stage_code), .internal_clock_stable(internal_clock_stable),
    .regime(regime), .corr_pulse(corr_pulse));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Oscillator rises every 4 clocks, base every 16, so gaps are exact
  initial tick = 4'h0;
  always @(posedge clk) #1 tick = tick + 4'h1;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rng(input string what, input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, v);
    end
  endtask : rng
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // Preload write; one pulse, outputs checked just after the taking edge
  task automatic wr(input logic d, input logic [7:0] v);
    step();
    if (d) begin
      wr_div = 1'b1;
      wr_div_data = v[3:0];
    end else begin
      wr_stage = 1'b1;
      wr_stage_data = v;
    end
    step();
    wr_div = 1'b0;
    wr_stage = 1'b0;
  endtask : wr
  task automatic wait_corr(output int c);
    c = 0;
    do begin
      step();
      c++;
    end while (corr_pulse !== 1'b1 && c < 3000);
    rng("correction wait", c, 1, 2999);
  endtask : wait_corr
  task automatic wait_reg(input logic [1:0] r);
    n = 0;
    while (regime !== r && n < 3000) begin
      step();
      n++;
    end
    chk("regime", 8'(r), 8'(regime));
  endtask : wait_reg
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    #100us;
    bad_count++;
    $display("wrong value watchdog expected done seen hang");
    results();
  end
  initial begin
    nrst = 1'b0;
    internal_gen_on = 1'b0;
    mult_n = 7'h02;
    err_pct = 8'h00;
    err_slow = 1'b1;
    {wr_div, wr_stage, wr_div_data, wr_stage_data} = '0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    step();
    chk("divider", 8'(`CLS_DIV_RST), 8'(osc_divider_code));
    chk("stage", `CLS_STAGE_RST, osc_stage_code);
    chk("flags", 8'h00, {4'h0, internal_clock_stable, corr_pulse, regime});
    $display("test reset done");
    wr(1'b1, 8'h0C);
    chk("divider", 8'(`CLS_DIV_MAX), 8'(osc_divider_code));
    wr(1'b1, 8'h03);
    wr(1'b0, 8'h5A);
    chk("preload", 8'h3A, {osc_divider_code, osc_stage_code[3:0]});
    err_pct = 8'h1E;
    internal_gen_on = 1'b1;
    wait_reg(CLS_COARSE);
    chk("start", 8'h3A, {osc_divider_code, osc_stage_code[3:0]});
    chk("start stage", 8'h5A, osc_stage_code);
    wr(1'b1, 8'h07);
    chk("divider while on", 8'h03, 8'(osc_divider_code));
    for (int k = 1; k <= 9; k++) begin
      wait_corr(cyc);
      if (k == 2) rng("coarse gap", cyc, 40, 48);
      if (k == 9) rng("doubled gap", cyc, 84, 92);
      if (k == 8) chk("after eight", 8'h45, {osc_divider_code, osc_stage_code[7:4]});
    end
    $display("test coarse done");
    err_pct = 8'h0A;
    err_slow = 1'b0;
    wait_reg(CLS_MEDIUM);
    s0 = osc_stage_code;
    n = 0;
    while (regime !== CLS_FINE && n < 9) begin
      wait_corr(cyc);
      n++;
      if (n == 1) chk("medium step", s0 - 8'h04, osc_stage_code);
      if (n == 2) rng("medium gap", cyc, 60, 68);
      if (n == 2) err_pct = 8'h03;
    end
    rng("medium count", n, 2, 8);
    chk("stable", 8'h01, 8'(internal_clock_stable));
    $display("test medium done");
    err_slow = 1'b1;
    s0 = osc_stage_code;
    wait_corr(cyc);
    chk("fine step", s0 + 8'h01, osc_stage_code);
    wait_corr(cyc);
    rng("fine gap", cyc, 60, 68);
    n = 0;
    repeat (1800) begin
      step();
      if (corr_pulse === 1'b1) n++;
    end
    rng("fine count", n, 22, 22);
    $display("test fine done");
    internal_gen_on = 1'b0;
    step();
    step();
    chk("off flags", 8'h00, {5'h0, internal_clock_stable, regime});
    $display("test off done");
    // Software rescale while off: power of two, stage overflow, divider overflow
    d0 = osc_divider_code;
    s0 = osc_stage_code;
    wr(1'b1, 8'(d0 + 4'h1));
    chk("scaled divider", 8'(d0 + 4'h1), 8'(osc_divider_code));
    chk("scaled stage", s0, osc_stage_code);
    wr(1'b0, 8'hC0);
    n = 32'(osc_stage_code) * 3 / 2;
    if (n > 255) begin
      wr(1'b0, 8'(n / 2));
      wr(1'b1, 8'(osc_divider_code + 4'h1));
    end
    chk("halved stage", 8'h90, osc_stage_code);
    chk("bumped divider", 8'(d0 + 4'h2), 8'(osc_divider_code));
    n = 32'(osc_divider_code) + 8;
    wr(1'b1, (n > 9) ? 8'h09 : 8'(n));
    chk("error path divider", 8'h09, 8'(osc_divider_code));
    internal_gen_on = 1'b1;
    wait_reg(CLS_COARSE);
    chk("restart", 8'h99, {osc_divider_code, osc_stage_code[7:4]});
    $display("test rescale done");
    results();
  end
endmodule : tb
